// >>> prm_pkg.sv
/*
 * Constants and carrier types for the port receive checks and FIFO status
 * block. Assumes a single clock domain and a simple register port.
 */
package prm_pkg;
   // Register offsets, at the printed word addresses
   localparam logic [7:0] GAP_ERR_CNT_ADDR = 8'hae;
   localparam logic [7:0] CRC_EN_ADDR      = 8'hb4;
   localparam logic [7:0] MIN_GAP_ADDR     = 8'hb5;
   localparam logic [7:0] MAX_LEN_ADDR     = 8'hb6;
   localparam logic [7:0] MIN_LEN_ADDR     = 8'hb7;
   localparam logic [7:0] LO_FRAMES_ADDR   = 8'hb8;
   localparam logic [7:0] HI_FRAMES_ADDR   = 8'hb9;
   localparam logic [7:0] LO_FILL_ADDR     = 8'hba;
   localparam logic [7:0] HI_FILL_ADDR     = 8'hbb;
   localparam logic [7:0] XP_FILL_ADDR     = 8'hbc;
   localparam logic [7:0] HEAD_LEN_ADDR    = 8'hc0;
   localparam logic [7:0] RX_DATA_ADDR     = 8'hc1;
   // Values after reset
   localparam logic        CRC_EN_RESET  = 1'h1;
   localparam logic [5:0]  MIN_GAP_RESET = 6'ha;
   localparam logic [15:0] MAX_LEN_RESET = 16'h0618;
   localparam logic [15:0] MIN_LEN_RESET = 16'h0040;
   // Gap unit in bit times, and the prepended header length in bytes
   localparam int          GAP_UNIT_BITS = 8;
   localparam logic [10:0] HDR_BYTES     = 11'h002;
   localparam logic [10:0] WORD_BYTES    = 11'h004;

   // One received frame as seen at its end
   typedef struct packed {
      logic [15:0] gap_bits;   // Idle bit times before the frame
      logic [15:0] len;        // Frame length in bytes
      logic        fcs_ok;     // Frame check sequence good
      logic        high_prio;  // Queue selection
   } prm_frame_type;

   // Register access request
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } prm_req_type;

   typedef enum logic [1:0] {
      HEAD_WAIT  = 2'b01,
      HEAD_ARMED = 2'b10
   } prm_head_type;
endpackage

// >>> prm_queue_model.sv
/*
 * Behavioural model of the second port receive queue head that feeds the
 * frame read path. Assumes the block pops one word per head_pop pulse.
 */
`timescale 1ns/10ps
module prm_queue_model #(
   parameter logic [10:0] FRAME_LEN = 11'h005
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // Control from the bench
   input  wire logic        load,
   // Queue head towards the block
   input  wire logic        head_pop,
   output logic             head_valid,
   output logic [10:0]      head_len,
   output logic [31:0]      head_word,
   output int               pop_count
);
   int idx;

   // Word index advances only on a pop, so a missed pop shows as stale data
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         idx       <= 0;
         pop_count <= 0;
      end else if (head_pop) begin
         idx       <= idx + 1;
         pop_count <= pop_count + 1;
      end
   end

   // Released data lines show an inverted pattern rather than a stale word
   assign head_valid = load;
   assign head_len   = FRAME_LEN;
   assign head_word  = load ? 32'ha0a1a2a3 + 32'(idx) * 32'h04040404 : ~32'ha0a1a2a3;
endmodule

// >>> prm_rx_status.sv
/*
 * Receive checks, queue fill bookkeeping and the head-of-queue frame read
 * path for one switch port. Assumes the SPI engine turns host accesses into
 * one-cycle register requests and that the link side reports each frame end.
 */
// How it works
// [R1] Drop bad-FCS frames while check enable set
// [R2] Gap must exceed setting times eight bits
// [R3] Short gap drops frame, flags gap error
// [R4] Gap setting six bits, upper bits zero
// [R5] Sixteen-bit max length, resets to 0x618
// [R6] Sixteen-bit min length, resets to 0x40
// [R7] Nine-bit low queue frame count
// [R8] Nine-bit high queue frame count
// [R9] Host only needs frame-available indication
// [R10] Fourteen-bit low queue halfword fill
// [R11] Fourteen-bit high queue halfword fill
// [R12] Fourteen-bit cross-port transmit halfword fill
// [R13] Eleven-bit head frame byte length
// [R14] Head length includes prepended header
// [R15] Host reads head length before data
// [R16] Head length used only in generic mode
// [R17] Data read pops four bytes, first high
// [R18] After frame end, data waits for length read
// [R19] Thirty-two-bit gap error frame counter
// [R20] Out-of-range lengths dropped as length errors
// [R21] Counts update per frame; reserved bits zero
`timescale 1ns/10ps
module prm_rx_status (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   // Register port
   input  wire prm_pkg::prm_req_type   req,
   output logic                        rvalid,
   output logic [31:0]                 rdata,
   // Received frame ends on the port
   input  wire logic                   rx_eof,
   input  wire prm_pkg::prm_frame_type rx_frame,
   // Host drained one frame from a queue
   input  wire logic                   lo_take,
   input  wire logic                   hi_take,
   input  wire logic [13:0]            take_halfwords,
   // Cross-port transmit queue movement
   input  wire logic                   xp_add,
   input  wire logic                   xp_sub,
   input  wire logic [13:0]            xp_halfwords,
   // Second port receive queue head
   input  wire logic                   spi_generic,
   input  wire logic                   head_valid,
   input  wire logic [10:0]            head_len,
   input  wire logic [31:0]            head_word,
   output logic                        head_pop,
   // Status
   output logic                        short_gap_error,
   output logic                        len_error,
   output logic                        rx_frame_available
);
   logic                 fcs_verify_on;
   logic [5:0]           rx_min_gap_setting;
   logic [15:0]          longest_rx_frame;
   logic [15:0]          shortest_rx_frame;
   logic [31:0]          short_gap_error_counter;
   logic [8:0]           low_queue_frame_count;
   logic [8:0]           high_queue_frame_count;
   logic [13:0]          low_queue_fill;
   logic [13:0]          high_queue_fill;
   logic [13:0]          cross_port_fill;
   logic [10:0]          head_frame_byte_len;
   logic [10:0]          bytes_left;
   prm_pkg::prm_head_type head_state;
   logic [31:0]          next_rdata;
   logic                 gap_short;
   logic                 len_bad;
   logic                 fcs_bad;
   logic                 accept;
   logic                 accept_lo;
   logic                 accept_hi;
   logic [13:0]          frame_halfwords;
   logic [15:0]          gap_need;
   logic                 len_rd;
   logic                 data_rd;
   logic                 wr_hit;

   // Frame checks at frame end
   assign gap_need  = {7'h00, rx_min_gap_setting, 3'h0}; // Setting times eight
   assign gap_short = !(rx_frame.gap_bits > gap_need); // R2
   assign len_bad   = (rx_frame.len < shortest_rx_frame) ||
                      (rx_frame.len > longest_rx_frame); // R20
   assign fcs_bad   = fcs_verify_on && !rx_frame.fcs_ok; // R1
   assign accept    = rx_eof && !gap_short && !len_bad && !fcs_bad; // R3
   assign accept_lo = accept && !rx_frame.high_prio;
   assign accept_hi = accept && rx_frame.high_prio;
   // Odd lengths occupy a whole trailing halfword
   // Limitation: a length of 0xffff wraps to zero halfwords if max allows it
   assign frame_halfwords = 14'((rx_frame.len + 16'h0001) >> 1);
   assign len_rd  = req.rd && (req.addr == prm_pkg::HEAD_LEN_ADDR);
   assign data_rd = req.rd && (req.addr == prm_pkg::RX_DATA_ADDR);
   assign wr_hit  = req.wr;

   // Writable settings; only the documented field bits are stored
   // Writes to read-only or unmapped offsets fall through and change nothing
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fcs_verify_on      <= prm_pkg::CRC_EN_RESET; // R1
         rx_min_gap_setting <= prm_pkg::MIN_GAP_RESET; // R2
         longest_rx_frame   <= prm_pkg::MAX_LEN_RESET; // R5
         shortest_rx_frame  <= prm_pkg::MIN_LEN_RESET; // R6
      end else if (wr_hit) begin
         if (req.addr == prm_pkg::CRC_EN_ADDR) begin
            fcs_verify_on <= req.wdata[0];
         end else if (req.addr == prm_pkg::MIN_GAP_ADDR) begin
            rx_min_gap_setting <= req.wdata[5:0]; // R4
         end else if (req.addr == prm_pkg::MAX_LEN_ADDR) begin
            longest_rx_frame <= req.wdata[15:0]; // R5
         end else if (req.addr == prm_pkg::MIN_LEN_ADDR) begin
            shortest_rx_frame <= req.wdata[15:0]; // R6
         end
      end
   end

   // Error pulses and the gap error counter
   // The gap check wins over the length check, so one frame raises one pulse
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         short_gap_error         <= 1'b0;
         len_error               <= 1'b0;
         short_gap_error_counter <= 32'h0000_0000;
      end else begin
         short_gap_error <= rx_eof && gap_short; // R3
         len_error       <= rx_eof && !gap_short && len_bad; // R20
         if (rx_eof && gap_short) begin
            short_gap_error_counter <= short_gap_error_counter + 32'h0000_0001; // R19
         end
      end
   end

   // Queue frame counts; an arrival and a take in one cycle cancel out
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         low_queue_frame_count  <= 9'h000;
         high_queue_frame_count <= 9'h000;
      end else begin
         if (accept_lo && !lo_take) begin
            low_queue_frame_count <= low_queue_frame_count + 9'h001; // R7
         end else if (lo_take && !accept_lo && low_queue_frame_count != 9'h000) begin
            low_queue_frame_count <= low_queue_frame_count - 9'h001; // R21
         end
         if (accept_hi && !hi_take) begin
            high_queue_frame_count <= high_queue_frame_count + 9'h001; // R8
         end else if (hi_take && !accept_hi && high_queue_frame_count != 9'h000) begin
            high_queue_frame_count <= high_queue_frame_count - 9'h001; // R21
         end
      end
   end

   // Halfword fill levels, moved by whole frames
   // Fills wrap rather than saturate; the far side is trusted to take only
   // what it was given, which keeps the adders free of clamp logic
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         low_queue_fill  <= 14'h0000;
         high_queue_fill <= 14'h0000;
         cross_port_fill <= 14'h0000;
      end else begin
         low_queue_fill <= low_queue_fill
                           + (accept_lo ? frame_halfwords : 14'h0000)
                           - (lo_take ? take_halfwords : 14'h0000); // R10
         high_queue_fill <= high_queue_fill
                            + (accept_hi ? frame_halfwords : 14'h0000)
                            - (hi_take ? take_halfwords : 14'h0000); // R11
         cross_port_fill <= cross_port_fill
                            + (xp_add ? xp_halfwords : 14'h0000)
                            - (xp_sub ? xp_halfwords : 14'h0000); // R12
      end
   end

   // Frame-available flag is all software needs in store and forward
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_frame_available <= 1'b0;
      end else begin
         rx_frame_available <= (low_queue_frame_count != 9'h000) ||
                               (high_queue_frame_count != 9'h000); // R9
      end
   end

   // Head length read arms the data path for one frame
   // The length is latched at arming so a head change mid-frame cannot
   // shorten or stretch the read-out already under way
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         head_state          <= prm_pkg::HEAD_WAIT;
         head_frame_byte_len <= 11'h000;
         bytes_left          <= 11'h000;
         head_pop            <= 1'b0;
      end else begin
         head_pop <= 1'b0;
         // Shown length tracks the queue head plus its header
         head_frame_byte_len <= head_valid ? head_len + prm_pkg::HDR_BYTES : 11'h000; // R14
         case (head_state)
            prm_pkg::HEAD_WAIT: begin
               if (len_rd && spi_generic && head_valid) begin // R16
                  head_state <= prm_pkg::HEAD_ARMED; // R15
                  bytes_left <= head_frame_byte_len;
               end
            end
            prm_pkg::HEAD_ARMED: begin
               if (data_rd) begin
                  head_pop <= 1'b1; // R17
                  if (bytes_left <= prm_pkg::WORD_BYTES) begin
                     // Frame done: hold off until the length is read again
                     head_state <= prm_pkg::HEAD_WAIT; // R18
                     bytes_left <= 11'h000;
                  end else begin
                     bytes_left <= bytes_left - prm_pkg::WORD_BYTES;
                  end
               end
            end
            default: begin
               head_state <= prm_pkg::HEAD_WAIT;
            end
         endcase
      end
   end

   // Read decode; unmapped and reserved bits return zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (req.addr == prm_pkg::GAP_ERR_CNT_ADDR) begin
         next_rdata = short_gap_error_counter; // R19
      end else if (req.addr == prm_pkg::CRC_EN_ADDR) begin
         next_rdata = {31'h0000_0000, fcs_verify_on};
      end else if (req.addr == prm_pkg::MIN_GAP_ADDR) begin
         next_rdata = {26'h000_0000, rx_min_gap_setting}; // R4
      end else if (req.addr == prm_pkg::MAX_LEN_ADDR) begin
         next_rdata = {16'h0000, longest_rx_frame};
      end else if (req.addr == prm_pkg::MIN_LEN_ADDR) begin
         next_rdata = {16'h0000, shortest_rx_frame};
      end else if (req.addr == prm_pkg::LO_FRAMES_ADDR) begin
         next_rdata = {23'h00_0000, low_queue_frame_count}; // R7
      end else if (req.addr == prm_pkg::HI_FRAMES_ADDR) begin
         next_rdata = {23'h00_0000, high_queue_frame_count}; // R8
      end else if (req.addr == prm_pkg::LO_FILL_ADDR) begin
         next_rdata = {18'h0_0000, low_queue_fill}; // R21
      end else if (req.addr == prm_pkg::HI_FILL_ADDR) begin
         next_rdata = {18'h0_0000, high_queue_fill};
      end else if (req.addr == prm_pkg::XP_FILL_ADDR) begin
         next_rdata = {18'h0_0000, cross_port_fill};
      end else if (req.addr == prm_pkg::HEAD_LEN_ADDR) begin
         next_rdata = {21'h00_0000, head_frame_byte_len}; // R13
      end else if (req.addr == prm_pkg::RX_DATA_ADDR) begin
         // Nothing comes out unless a frame is armed
         next_rdata = (head_state == prm_pkg::HEAD_ARMED) ? head_word : 32'h0000_0000; // R17
      end
   end

   // Read answer one cycle after the request
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
      end else begin
         rvalid <= req.rd;
         if (req.rd) begin
            rdata <= next_rdata;
         end
      end
   end

   // Checks
   // Each one watches state or outputs that this block drives itself
   a_gap_error_flag: assert property (@(posedge clk) disable iff (!arst_n) // R3
      rx_eof && (rx_frame.gap_bits <= {7'h00, rx_min_gap_setting, 3'h0})
      |=> short_gap_error)
      else $error("short gap not flagged");
   a_gap_counter_step: assert property (@(posedge clk) disable iff (!arst_n) // R19
      short_gap_error |-> short_gap_error_counter == $past(short_gap_error_counter) + 32'h1)
      else $error("gap error counter did not step");
   a_bad_fcs_drop: assert property (@(posedge clk) disable iff (!arst_n) // R1
      rx_eof && fcs_verify_on && !rx_frame.fcs_ok && !lo_take && !rx_frame.high_prio
      |=> low_queue_frame_count == $past(low_queue_frame_count))
      else $error("bad fcs frame entered low queue");
   a_long_frame_drop: assert property (@(posedge clk) disable iff (!arst_n) // R20
      rx_eof && rx_frame.len > longest_rx_frame && !hi_take && rx_frame.high_prio
      |=> high_queue_frame_count == $past(high_queue_frame_count))
      else $error("long frame entered high queue");
   a_good_frame_count: assert property (@(posedge clk) disable iff (!arst_n) // R7
      accept_lo && !lo_take |=> low_queue_frame_count == $past(low_queue_frame_count) + 9'h1)
      else $error("good frame not counted");
   a_gap_field_width: assert property (@(posedge clk) disable iff (!arst_n) // R4
      rvalid && $past(req.addr) == prm_pkg::MIN_GAP_ADDR |-> rdata[31:6] == 26'h0)
      else $error("gap register upper bits not zero");
   a_head_header_add: assert property (@(posedge clk) disable iff (!arst_n) // R14
      head_valid |=> head_frame_byte_len == $past(head_len) + prm_pkg::HDR_BYTES)
      else $error("head length lacks header");
   a_data_needs_len: assert property (@(posedge clk) disable iff (!arst_n) // R18
      head_state == prm_pkg::HEAD_WAIT && !(len_rd && spi_generic) ##1 data_rd |=> !head_pop)
      else $error("data popped without length read");
   a_alt_mode_idle: assert property (@(posedge clk) disable iff (!arst_n) // R16
      !spi_generic && head_state == prm_pkg::HEAD_WAIT |=> head_state == prm_pkg::HEAD_WAIT)
      else $error("armed outside generic mode");
   a_avail_flag: assert property (@(posedge clk) disable iff (!arst_n) // R9
      low_queue_frame_count != 9'h0 |=> rx_frame_available)
      else $error("frame available not shown");
endmodule

// >>> prm_rx_status_tb.sv
/*
 * Self-checking bench for the port receive checks and queue status block.
 * Assumes the queue head model is compiled first; the bench drives its inputs at falling edges.
 */
`timescale 1ns/10ps
module prm_rx_status_tb;
   logic                   clk, arst_n, rvalid, rx_eof, lo_take, hi_take, xp_add, xp_sub;
   logic                   spi_generic, head_valid, head_pop, load;
   logic                   short_gap_error, len_error, rx_frame_available;
   prm_pkg::prm_req_type   req;
   prm_pkg::prm_frame_type rx_frame;
   logic [31:0]            rdata, head_word;
   logic [13:0]            take_halfwords, xp_halfwords;
   logic [10:0]            head_len;
   int                     num_errors, checked, pops;

   prm_rx_status u_prm_rx_status (.clk(clk), .arst_n(arst_n), .req(req), .rvalid(rvalid),
      .rdata(rdata), .rx_eof(rx_eof), .rx_frame(rx_frame), .lo_take(lo_take),
      .hi_take(hi_take), .take_halfwords(take_halfwords), .xp_add(xp_add), .xp_sub(xp_sub),
      .xp_halfwords(xp_halfwords), .spi_generic(spi_generic), .head_valid(head_valid),
      .head_len(head_len), .head_word(head_word), .head_pop(head_pop),
      .short_gap_error(short_gap_error), .len_error(len_error),
      .rx_frame_available(rx_frame_available));
   prm_queue_model u_prm_queue_model (.clk(clk), .arst_n(arst_n), .load(load),
      .head_pop(head_pop), .head_valid(head_valid), .head_len(head_len),
      .head_word(head_word), .pop_count(pops));

   // Free-running 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, seen);
         num_errors++;
      end
   endtask

   // Register write: one-cycle request pulse
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(negedge clk);
      req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge clk);
      req.wr = 1'b0;
   endtask

   // Register read with a bounded wait for the answer, then compare
   task automatic rdchk(logic [7:0] a, logic [31:0] exp);
      int n;
      @(negedge clk);
      req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
      @(negedge clk);
      req.rd = 1'b0;
      n = 0;
      while (rvalid !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      if (rvalid !== 1'b1) begin
         num_errors++;
         test_done();
      end else begin
         check($sformatf("reg %h", a), rdata, exp);
      end
   endtask

   // One frame end; error pulses are looked at in the cycle they stand
   task automatic frm(logic [15:0] gap, logic [15:0] len, logic ok, logic hp, logic es,
                      logic el);
      @(negedge clk);
      rx_eof   = 1'b1;
      rx_frame = '{gap_bits: gap, len: len, fcs_ok: ok, high_prio: hp};
      @(negedge clk);
      rx_eof = 1'b0;
      check("short_gap_error", {31'h0, short_gap_error}, {31'h0, es});
      check("len_error", {31'h0, len_error}, {31'h0, el});
   endtask

   task automatic t_reset();
      logic [7:0]  addr [12] = '{8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'hb8, 8'hb9, 8'hba, 8'hbb,
                                 8'hbc, 8'hae, 8'hc0, 8'h00};
      logic [31:0] exp [12] = '{32'h1, 32'ha, 32'h618, 32'h40, 32'h0, 32'h0, 32'h0,
                                32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 12; i++) begin
         rdchk(addr[i], exp[i]);
      end
   endtask

   task automatic t_regs();
      wr(8'hb5, 32'hffffffff);
      rdchk(8'hb5, 32'h3f);
      wr(8'hb4, 32'hfffffffe);
      rdchk(8'hb4, 32'h0);
      wr(8'hb6, 32'hffffffff);
      rdchk(8'hb6, 32'hffff);
      wr(8'hb7, 32'hffff1234);
      rdchk(8'hb7, 32'h1234);
      wr(8'hb8, 32'hffffffff);
      rdchk(8'hb8, 32'h0);
      wr(8'hb4, 32'h1);
      wr(8'hb5, 32'ha);
      wr(8'hb6, 32'h618);
      wr(8'hb7, 32'h40);
   endtask

   // Gap boundaries at the reset setting and at the largest setting
   task automatic t_gap();
      frm(16'd80, 16'd100, 1'b1, 1'b0, 1'b1, 1'b0);
      frm(16'd81, 16'h41, 1'b1, 1'b0, 1'b0, 1'b0);
      rdchk(8'hb8, 32'h1);
      rdchk(8'hba, 32'h21);
      check("rx_frame_available", {31'h0, rx_frame_available}, 32'h1);
      wr(8'hb5, 32'h3f);
      frm(16'd504, 16'd10, 1'b1, 1'b1, 1'b1, 1'b0);
      frm(16'd505, 16'd100, 1'b1, 1'b1, 1'b0, 1'b0);
      rdchk(8'hb9, 32'h1);
      rdchk(8'hbb, 32'h32);
      rdchk(8'hae, 32'h2);
      wr(8'hb5, 32'ha);
   endtask

   task automatic t_len_crc();
      frm(16'd200, 16'h3f, 1'b1, 1'b0, 1'b0, 1'b1);
      frm(16'd200, 16'h619, 1'b1, 1'b1, 1'b0, 1'b1);
      frm(16'd200, 16'h40, 1'b1, 1'b0, 1'b0, 1'b0);
      frm(16'd200, 16'h618, 1'b1, 1'b0, 1'b0, 1'b0);
      frm(16'd200, 16'd100, 1'b0, 1'b0, 1'b0, 1'b0);
      rdchk(8'hb8, 32'h3);
      wr(8'hb4, 32'h0);
      frm(16'd200, 16'd100, 1'b0, 1'b0, 1'b0, 1'b0);
      rdchk(8'hb8, 32'h4);
      rdchk(8'hba, 32'h37f);
      wr(8'hb4, 32'h1);
   endtask

   // Drain both queue fills with one take each (low frame count drops from 4 to 3) and move the cross-port fill both ways
   task automatic t_take();
      @(negedge clk);
      lo_take        = 1'b1;
      take_halfwords = 14'h37f;
      xp_add         = 1'b1;
      xp_halfwords   = 14'h123;
      @(negedge clk);
      lo_take        = 1'b0;
      hi_take        = 1'b1;
      take_halfwords = 14'h32;
      xp_add         = 1'b0;
      xp_sub         = 1'b1;
      xp_halfwords   = 14'h23;
      @(negedge clk);
      hi_take = 1'b0;
      xp_sub  = 1'b0;
      rdchk(8'hb8, 32'h3);
      rdchk(8'hba, 32'h0);
      rdchk(8'hb9, 32'h0);
      rdchk(8'hbb, 32'h0);
      rdchk(8'hbc, 32'h100);
   endtask

   // Head length arms the data window for exactly one frame
   task automatic t_head();
      load = 1'b1;
      rdchk(8'hc1, 32'h0);
      rdchk(8'hc0, 32'h7);
      rdchk(8'hc1, 32'h0);
      check("pops", 32'(pops), 32'h0);
      spi_generic = 1'b1;
      rdchk(8'hc0, 32'h7);
      rdchk(8'hc1, 32'ha0a1a2a3);
      rdchk(8'hc1, 32'ha4a5a6a7);
      rdchk(8'hc1, 32'h0);
      check("pops", 32'(pops), 32'h2);
      rdchk(8'hc0, 32'h7);
      rdchk(8'hc1, 32'ha8a9aaab);
   endtask

   // Main sequence
   initial begin
      arst_n = 1'b0;
      req = '0;
      rx_eof = 1'b0;
      rx_frame = '0;
      {lo_take, hi_take, xp_add, xp_sub, spi_generic, load} = '0;
      take_halfwords = '0;
      xp_halfwords = '0;
      num_errors = 0;
      checked = 0;
      repeat (10) @(negedge clk);
      arst_n = 1'b1;
      t_reset();
      t_regs();
      t_gap();
      t_len_crc();
      t_take();
      t_head();
      test_done();
   end
endmodule
